// File: rtl/poc_pkg.sv
// package: constants and types for the pipelined converter output control
package poc_pkg;

  // ----------------------------------------------------------------------
  // widths and pipeline shape
  // ----------------------------------------------------------------------
  localparam int RES_W    = 14;          // result bus width
  localparam int ANA_W    = 16;          // width of the digitised input
  localparam int STAGES   = 6;           // pipelined conversion stages
  localparam int LATENCY  = 5;           // sampling clocks to output
  localparam int DCS_W    = 9;           // stabilizer period counter width

  // bits resolved by each stage, first stage in entry 0
  localparam logic [STAGES-1:0][RES_W-1:0] STAGE_MASK = {
    14'h0003, 14'h000C, 14'h0030, 14'h00C0, 14'h0700, 14'h3800
  };

  // ----------------------------------------------------------------------
  // input range and codes
  // ----------------------------------------------------------------------
  localparam logic signed [ANA_W-1:0] ANA_MIN    = 16'shE000;
  localparam logic signed [ANA_W-1:0] ANA_MAX    = 16'sh1FFF;
  localparam logic signed [ANA_W-1:0] ANA_OFFSET = 16'sh2000;
  localparam logic [RES_W-1:0]        CODE_MIN   = 14'h0000;
  localparam logic [RES_W-1:0]        CODE_MAX   = 14'h3FFF;
  localparam logic [RES_W-1:0]        RESULT_RST = 14'h0000;

  // ----------------------------------------------------------------------
  // four-level format strap
  // ----------------------------------------------------------------------
  localparam logic [1:0] STRAP_GND       = 2'h0;
  localparam logic [1:0] STRAP_THIRD     = 2'h1;
  localparam logic [1:0] STRAP_TWO_THIRD = 2'h2;
  localparam logic [1:0] STRAP_FULL      = 2'h3;
  localparam logic [1:0] STRAP_RST       = STRAP_GND;

  // operating mode, coded as {power_down_select, output_enable_n}
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_HIZ    = 2'b01,
    MODE_NAP    = 2'b10,
    MODE_SLEEP  = 2'b11
  } poc_op_mode_type;

  // one pipeline slot: residue still to resolve plus per-stage digits
  typedef struct packed {
    logic                         ovf;
    logic [RES_W-1:0]             residue;
    logic [STAGES-1:0][RES_W-1:0] digits;
  } poc_stage_type;

  // merged conversion result
  typedef struct packed {
    logic             ovf;
    logic [RES_W-1:0] code;
  } poc_result_type;

endpackage

// File: rtl/poc_pipe_stage.sv
// one pipelined conversion stage: resolves its bits, passes the residue
`timescale 1ns/10ps
module poc_pipe_stage #(
  parameter logic [13:0] MASK = 14'h3FFF,
  parameter int          IDX  = 0
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  // phase control
  input  wire logic                  step,
  input  wire logic                  flush,
  // residue in and out
  input  wire poc_pkg::poc_stage_type stage_in,
  output      poc_pkg::poc_stage_type stage_out
);

  poc_pkg::poc_stage_type stage_q;
  poc_pkg::poc_stage_type stage_d;

  // acquire previous residue on this stage's phase
  always_comb begin
    stage_d = stage_q;
    if (flush) begin
      stage_d = '0;
    end else if (step) begin
      stage_d              = stage_in;
      stage_d.digits[IDX]  = stage_in.residue & MASK;
      stage_d.residue      = stage_in.residue & ~MASK;
    end
  end

  // stage register
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      stage_q <= '0;
    end else begin
      stage_q <= stage_d;
    end
  end

  assign stage_out = stage_q;

endmodule

// File: rtl/poc_output_control.sv
// top: sample/hold, six-stage pipeline, correction and output drive
`timescale 1ns/10ps

// What this block does
// R01: the input is tracked while the sampling clock is low and frozen on its rise.
// R02: each conversion starts on a rise of the single-ended sampling clock.
// R03: a sample's result reaches the bus five sampling clocks later via six stages.
// R04: odd stages step on one clock half and even stages on the other.
// R05: stage digits are time aligned and merged in correction logic before output.
// R06: power-down low and enable low gives normal conversion with outputs driven.
// R07: power-down low and enable high keeps converting with outputs released.
// R08: power-down high and enable low is nap mode with outputs released.
// R09: power-down high and enable high is sleep mode with outputs released.
// R10: the result is fourteen bits with the highest bit most significant.
// R11: the range flag is high for any result whose sample was out of range.
// R12: strap at ground or one third gives offset binary, else two's complement.
// R13: strap at one third or two thirds turns the duty cycle stabilizer on.
// R14: two's complement is offset binary with the top bit inverted.
// R15: capture logic registers the bus once per clock and ignores it when released.
module poc_output_control #(
  parameter int DCS_W = poc_pkg::DCS_W
) (
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rstn,
  // sampling clock and digitised analog input
  input  wire logic                         sample_clk,
  input  wire logic signed [poc_pkg::ANA_W-1:0] analog_in,
  // straps and mode pins
  input  wire logic [1:0]                   format_strap,
  input  wire logic                         power_down_select,
  input  wire logic                         output_enable_n,
  // result bus and range flag
  output      logic [poc_pkg::RES_W-1:0]    conversion_result_bits,
  output      logic                         result_oe,
  output      logic                         range_overflow_flag,
  output      logic                         flag_oe,
  // status
  output      logic                         dcs_enabled,
  output      logic                         twos_comp_sel,
  output      poc_pkg::poc_op_mode_type     op_mode
);

  // ----------------------------------------------------------------------
  // mode decode and strap capture
  // ----------------------------------------------------------------------
  logic       strap_done_q;
  logic       strap_done_d;
  logic [1:0] strap_q;
  logic [1:0] strap_d;
  logic       running;
  logic       flush;

  // mode straight from the two pins
  assign op_mode = poc_pkg::poc_op_mode_type'(
                     {power_down_select, output_enable_n});
  assign running = (op_mode == poc_pkg::MODE_NORMAL) ||
                   (op_mode == poc_pkg::MODE_HIZ);          // [R07] [R08]
  assign flush   = (op_mode == poc_pkg::MODE_SLEEP);        // [R09]

  // strap caught once, first cycle after reset release
  always_comb begin
    strap_d      = strap_q;
    strap_done_d = 1'b1;
    if (!strap_done_q) begin
      strap_d = format_strap;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      strap_q      <= poc_pkg::STRAP_RST;
      strap_done_q <= 1'b0;
    end else begin
      strap_q      <= strap_d;
      strap_done_q <= strap_done_d;
    end
  end

  // format and stabilizer from the strap level
  assign twos_comp_sel = (strap_q == poc_pkg::STRAP_TWO_THIRD) ||
                         (strap_q == poc_pkg::STRAP_FULL);  // [R12]
  assign dcs_enabled   = (strap_q == poc_pkg::STRAP_THIRD) ||
                         (strap_q == poc_pkg::STRAP_TWO_THIRD); // [R13]

  // ----------------------------------------------------------------------
  // sampling clock edges and duty cycle stabilizer
  // ----------------------------------------------------------------------
  logic             clk_prev_q;
  logic [DCS_W-1:0] per_cnt_q;
  logic [DCS_W-1:0] per_cnt_d;
  logic [DCS_W-1:0] half_q;
  logic [DCS_W-1:0] half_d;
  logic             raw_rise;
  logic             raw_fall;
  logic             dcs_fall;
  logic             rise_go;
  logic             fall_go;

  assign raw_rise = sample_clk & ~clk_prev_q;
  assign raw_fall = ~sample_clk & clk_prev_q;
  // regenerated falling edge at half the measured period
  assign dcs_fall = (per_cnt_q == half_q) && (half_q != '0) && !raw_rise;
  assign rise_go  = running & raw_rise;                     // [R02]
  assign fall_go  = running & (dcs_enabled ? dcs_fall : raw_fall); // [R13]

  // period counter, saturating for slow clocks; sleep forgets the
  // period so a stale half cannot skip the first low-half step
  always_comb begin
    per_cnt_d = per_cnt_q;
    half_d    = half_q;
    if (flush) begin
      per_cnt_d = '0;
      half_d    = '0;
    end else if (raw_rise) begin
      half_d    = per_cnt_q >> 1;
      per_cnt_d = '0;
    end else if (per_cnt_q != '1) begin
      per_cnt_d = per_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      clk_prev_q <= 1'b0;
      per_cnt_q  <= '0;
      half_q     <= '0;
    end else begin
      clk_prev_q <= sample_clk;
      per_cnt_q  <= per_cnt_d;
      half_q     <= half_d;
    end
  end

  // ----------------------------------------------------------------------
  // input sample and hold
  // ----------------------------------------------------------------------
  logic signed [poc_pkg::ANA_W-1:0] track_q;
  logic signed [poc_pkg::ANA_W-1:0] track_d;
  logic signed [poc_pkg::ANA_W-1:0] shifted;
  poc_pkg::poc_stage_type           hold_q;
  poc_pkg::poc_stage_type           hold_d;
  poc_pkg::poc_result_type          held_val;

  // clamp to range, flag anything outside it
  assign shifted = track_q + poc_pkg::ANA_OFFSET;
  always_comb begin
    held_val.ovf  = 1'b0;
    held_val.code = shifted[poc_pkg::RES_W-1:0];
    if (track_q > poc_pkg::ANA_MAX) begin
      held_val.ovf  = 1'b1;                                 // [R11]
      held_val.code = poc_pkg::CODE_MAX;
    end else if (track_q < poc_pkg::ANA_MIN) begin
      held_val.ovf  = 1'b1;                                 // [R11]
      held_val.code = poc_pkg::CODE_MIN;
    end
  end

  // track while low, freeze last low value on the rise
  always_comb begin
    track_d = track_q;
    hold_d  = hold_q;
    if (!sample_clk) begin
      track_d = analog_in;                                  // [R01]
    end
    if (flush) begin
      hold_d = '0;
    end else if (rise_go) begin
      hold_d         = '0;
      hold_d.ovf     = held_val.ovf;
      hold_d.residue = held_val.code;                       // [R01]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      track_q <= '0;
      hold_q  <= '0;
    end else begin
      track_q <= track_d;
      hold_q  <= hold_d;
    end
  end

  // ----------------------------------------------------------------------
  // six alternating pipeline stages
  // ----------------------------------------------------------------------
  poc_pkg::poc_stage_type   chain [0:poc_pkg::STAGES];
  logic [poc_pkg::STAGES-1:0] step_w;

  assign chain[0] = hold_q;

  genvar gi;
  generate
    for (gi = 0; gi < poc_pkg::STAGES; gi++) begin : g_stage
      // first, third, fifth on the low half; others on the rise
      assign step_w[gi] = ((gi % 2) == 0) ? fall_go : rise_go; // [R04]
      poc_pipe_stage #(
        .MASK (poc_pkg::STAGE_MASK[gi]),
        .IDX  (gi)
      ) u_stage (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .step      (step_w[gi]),
        .flush     (flush),
        .stage_in  (chain[gi]),
        .stage_out (chain[gi+1])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // correction and output register
  // ----------------------------------------------------------------------
  poc_pkg::poc_result_type  corr_q;
  poc_pkg::poc_result_type  corr_d;
  poc_pkg::poc_result_type  raw_q;
  poc_pkg::poc_result_type  raw_d;
  logic [poc_pkg::RES_W-1:0] merged;

  // merge aligned digits of all stages
  always_comb begin
    merged = '0;
    for (int k = 0; k < poc_pkg::STAGES; k++) begin
      merged = merged | chain[poc_pkg::STAGES].digits[k];   // [R05]
    end
  end

  always_comb begin
    corr_d = corr_q;
    raw_d  = raw_q;
    if (flush) begin
      corr_d = '0;
      raw_d  = '0;
    end else if (rise_go) begin
      corr_d.ovf  = chain[poc_pkg::STAGES].ovf;
      corr_d.code = merged;                                 // [R05]
      raw_d       = corr_q;                                 // [R03]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      corr_q <= '0;
      raw_q  <= '0;
    end else begin
      corr_q <= corr_d;
      raw_q  <= raw_d;
    end
  end

  // format applied at the pins, top bit carries most weight
  assign conversion_result_bits = {raw_q.code[poc_pkg::RES_W-1] ^ // [R10]
                                   twos_comp_sel,
                                   raw_q.code[poc_pkg::RES_W-2:0]}; // [R14]
  assign range_overflow_flag    = raw_q.ovf;                // [R11]
  assign result_oe = (op_mode == poc_pkg::MODE_NORMAL);     // [R06]
  assign flag_oe   = (op_mode == poc_pkg::MODE_NORMAL);     // [R06]

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  poc_pkg::poc_result_type ref_q [0:poc_pkg::LATENCY-1];
  logic [2:0]              fill_q;

  // reference delay line of held samples, one per rise
  always_ff @(posedge sys_clk) begin
    if (!rstn || flush) begin
      fill_q <= '0;
      for (int k = 0; k < poc_pkg::LATENCY; k++) begin
        ref_q[k] <= '0;
      end
    end else if (rise_go) begin
      ref_q[0] <= held_val;
      for (int k = 1; k < poc_pkg::LATENCY; k++) begin
        ref_q[k] <= ref_q[k-1];
      end
      if (fill_q != 3'(poc_pkg::LATENCY)) begin
        fill_q <= fill_q + 3'h1;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_out_update;
    rise_go && (fill_q == 3'(poc_pkg::LATENCY)) && !flush;
  endsequence

  chk_track_freeze: assert property (
    sample_clk && $past(sample_clk) |=> $stable(track_q))    // [R01]
    else $error("input moved while sampling clock high");
  chk_conv_start: assert property (
    $changed(hold_q) && !$past(flush) |-> $past(raw_rise))  // [R02]
    else $error("sample held without a rising edge");
  chk_latency_five: assert property (
    s_out_update |=> raw_q == $past(ref_q[poc_pkg::LATENCY-1])) // [R03]
    else $error("result not five sampling clocks after its sample");
  chk_phase_odd: assert property (
    $changed(chain[1]) && !$past(flush) |-> $past(fall_go)) // [R04]
    else $error("first stage stepped outside its phase");
  chk_phase_even: assert property (
    $changed(chain[2]) && !$past(flush) |-> $past(rise_go)) // [R04]
    else $error("second stage stepped outside its phase");
  chk_merge_done: assert property (
    chain[poc_pkg::STAGES].residue == '0)                   // [R05]
    else $error("residue left after last stage");
  chk_out_drive: assert property (
    !power_down_select && !output_enable_n |-> result_oe && flag_oe) // [R06]
    else $error("outputs not driven in normal mode");
  chk_out_hiz: assert property (
    power_down_select || output_enable_n |-> !result_oe && !flag_oe) // [R07]
    else $error("outputs driven while released");
  chk_nap_freeze: assert property (
    power_down_select && !output_enable_n |=> $stable(raw_q)) // [R08]
    else $error("pipeline advanced in nap mode");
  chk_sleep_flush: assert property (
    power_down_select && output_enable_n |=> hold_q == '0)  // [R09]
    else $error("pipeline kept in sleep mode");
  chk_range_flag: assert property (
    rise_go && (track_q > poc_pkg::ANA_MAX) && !flush
      |=> hold_q.ovf ##0 hold_q.residue == poc_pkg::CODE_MAX) // [R11]
    else $error("over range sample not flagged");
  chk_format_msb: assert property (
    strap_done_q && $stable(raw_q) && $changed(twos_comp_sel)
      |-> $changed(conversion_result_bits[poc_pkg::RES_W-1])) // [R14]
    else $error("format change did not flip top bit");

endmodule

// File: dv/poc_capture_model.sv
// capture model: latches the result bus once per sampling clock
`timescale 1ns/10ps
module poc_capture_model (
  // clock
  input  wire logic                        sys_clk,
  // bus from the converter
  input  wire logic                        sample_clk,
  input  wire logic [poc_pkg::RES_W-1:0]   conversion_result_bits,
  input  wire logic                        range_overflow_flag,
  input  wire logic                        result_oe,
  input  wire logic                        flag_oe,
  // captured value
  output      poc_pkg::poc_result_type     cap
);
  logic prev_q;

  // latch on each fall of the sampling clock, skip a released bus
  always_ff @(posedge sys_clk) begin
    prev_q <= sample_clk;
    if (prev_q && !sample_clk && result_oe && flag_oe) begin
      cap.code <= conversion_result_bits;
      cap.ovf  <= range_overflow_flag;
    end
  end
endmodule

// File: dv/poc_output_control_tb.sv
// testbench: straps, modes and result stream of the output control
`timescale 1ns/10ps
module poc_output_control_tb;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic                             sys_clk;
  logic                             rstn;
  logic                             sample_clk;
  logic signed [poc_pkg::ANA_W-1:0] analog_in;
  logic [1:0]                       format_strap;
  logic                             power_down_select;
  logic                             output_enable_n;
  logic [poc_pkg::RES_W-1:0]        conversion_result_bits;
  logic                             result_oe;
  logic                             range_overflow_flag;
  logic                             flag_oe;
  logic                             dcs_enabled;
  logic                             twos_comp_sel;
  poc_pkg::poc_op_mode_type         op_mode;
  poc_pkg::poc_result_type          cap;
  int                               failures = 0;
  int                               checked = 0;
  int                               cycles = 0;
  integer                           seed = 32'h99CD;
  logic                             twos = 1'b0;
  logic signed [poc_pkg::ANA_W-1:0] q[$];
  logic signed [poc_pkg::ANA_W-1:0] corner [7] = '{16'shE000,
    16'sh1FFF, 16'shDFFF, 16'sh2000, 16'sh8000, 16'sh7FFF, 16'sh0000};

  // --------------------------------------------------------------
  // design and capture model
  // --------------------------------------------------------------
  poc_output_control u_poc_output_control (
    .sys_clk, .rstn, .sample_clk, .analog_in, .format_strap,
    .power_down_select, .output_enable_n, .conversion_result_bits,
    .result_oe, .range_overflow_flag, .flag_oe, .dcs_enabled,
    .twos_comp_sel, .op_mode
  );
  poc_capture_model u_poc_capture_model (
    .sys_clk, .sample_clk, .conversion_result_bits,
    .range_overflow_flag, .result_oe, .flag_oe, .cap
  );

  // --------------------------------------------------------------
  // clock, timeout, helpers
  // --------------------------------------------------------------
  // 4 ns system clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // cut a hang short
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      report_and_stop();
    end
  end

  // code and flag expected for one held sample
  function automatic poc_pkg::poc_result_type expect_res(
      logic signed [poc_pkg::ANA_W-1:0] a, logic tc);
    poc_pkg::poc_result_type r;
    logic [poc_pkg::ANA_W-1:0]        t;
    t = a + poc_pkg::ANA_OFFSET;
    r.code = t[poc_pkg::RES_W-1:0];
    r.ovf = (a > poc_pkg::ANA_MAX) || (a < poc_pkg::ANA_MIN);
    if (a > poc_pkg::ANA_MAX) begin
      r.code = poc_pkg::CODE_MAX;
    end
    if (a < poc_pkg::ANA_MIN) begin
      r.code = poc_pkg::CODE_MIN;
    end
    r.code[poc_pkg::RES_W-1] = r.code[poc_pkg::RES_W-1] ^ tc;
    return r;
  endfunction

  // compare and count
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // reset with a strap level held, then check the strap decode
  task automatic do_reset(logic [1:0] s);
    @(negedge sys_clk);
    rstn = 1'b0;
    format_strap = s;
    sample_clk = 1'b0;
    q.delete();
    repeat (5) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    twos = s[1];
    check("dcs", 32'(dcs_enabled), 32'(s[0] ^ s[1]));
    check("twos", 32'(twos_comp_sel), 32'(s[1]));
  endtask

  // mode pins, then the decoded mode and output enables
  task automatic set_mode(logic [1:0] m);
    @(negedge sys_clk);
    {power_down_select, output_enable_n} = m;
    @(negedge sys_clk);
    check("op_mode", 32'(op_mode), 32'(m));
    check("result_oe", 32'(result_oe), 32'(m == 2'h0));
    check("flag_oe", 32'(flag_oe), 32'(m == 2'h0));
  endtask

  // one sampling period: low phase with v, compare capture, rise
  task automatic sclk_cycle(logic signed [poc_pkg::ANA_W-1:0] v,
                            logic conv);
    poc_pkg::poc_result_type e;
    @(negedge sys_clk);
    sample_clk = 1'b0;
    analog_in = v;
    repeat (3) @(negedge sys_clk);
    if (conv && q.size() == poc_pkg::LATENCY + 1) begin
      e = expect_res(q.pop_front(), twos);
      if (result_oe) begin
        check("code", 32'(cap.code), 32'(e.code));
        check("flag", 32'(cap.ovf), 32'(e.ovf));
      end
    end
    sample_clk = 1'b1;
    if (conv) begin
      q.push_back(v);
    end
    repeat (3) @(negedge sys_clk);
  endtask

  // random samples, most inside the range, some beyond it
  task automatic stream(int n, logic conv);
    logic signed [poc_pkg::ANA_W-1:0] v;
    for (int i = 0; i < n; i++) begin
      v = 16'($random(seed));
      if (i % 3 != 0) begin
        v = v >>> 2;
      end
      sclk_cycle(v, conv);
    end
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    sample_clk = 1'b0;
    analog_in = 16'sh0000;
    format_strap = 2'h0;
    power_down_select = 1'b0;
    output_enable_n = 1'b0;
    for (int s = 0; s < 4; s++) begin
      do_reset(2'(s));
      // every strap level: both formats, stabilizer on and off
      foreach (corner[i]) begin
        sclk_cycle(corner[i], 1'b1);
      end
      stream(24, 1'b1);
      set_mode(2'h1);
      stream(8, 1'b1);
      set_mode(2'h0);
      stream(8, 1'b1);
      set_mode(2'h2);
      stream(4, 1'b0);
      set_mode(2'h0);
      stream(8, 1'b1);
      set_mode(2'h3);
      repeat (3) @(negedge sys_clk);
      check("sleep_code", 32'(conversion_result_bits),
            32'({twos, 13'h0000}));
      check("sleep_flag", 32'(range_overflow_flag), 32'h0);
      q.delete();
      set_mode(2'h0);
      stream(12, 1'b1);
    end
    report_and_stop();
  end
endmodule
